// ### bcu_defines.vh
// Constants for the block copy and user data space move unit.
// Included by bcu_exec.v, the checker and the bench; bcu_buf2.v uses none of it; definitions only.
`ifndef BCU_DEFINES_VH
`define BCU_DEFINES_VH
`define BCU_PFX_ED 8'hED
`define BCU_OP_COPY 8'hB0
`define BCU_OP_ULD 8'h86
`define BCU_OP_UST 8'h8E
`define BCU_PFX_IDX 8'hDD
`define BCU_PFX_MASK 8'hDF
`define BCU_PFX_SEL 5
`define BCU_F_S 7
`define BCU_F_Z 6
`define BCU_F_H 4
`define BCU_F_V 2
`define BCU_F_N 1
`define BCU_F_C 0
`define BCU_ADR_CTRL 4'h0
`define BCU_ADR_STAT 4'h4
`define BCU_ADR_CNT 4'h8
`define BCU_CTRL_RST 1'h1
`endif

// ### bcu_buf2.v
// Two-entry valid/ready buffer for bytes in flight.
// Assumes one clock and a synchronous active-high reset.
`timescale 1ns/10ps
`default_nettype none
module bcu_buf2 #(
    parameter W = 8
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire in_valid_i,
    output wire in_ready_o,
    input wire [W-1:0] in_data_i,
    output wire out_valid_o,
    input wire out_ready_i,
    output wire [W-1:0] out_data_o
);
    reg [W-1:0] mem_reg [0:1];
    reg wp_reg;
    reg rp_reg;
    reg [1:0] cnt_reg;
    wire push = in_valid_i && (cnt_reg != 2'h2);
    wire pop = out_ready_i && (cnt_reg != 2'h0);
    assign in_ready_o = (cnt_reg != 2'h2);
    assign out_valid_o = (cnt_reg != 2'h0);
    assign out_data_o = mem_reg[rp_reg];
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            wp_reg <= 1'b0;
            rp_reg <= 1'b0;
            cnt_reg <= 2'h0;
        end else begin
            if (push) begin
                mem_reg[wp_reg] <= in_data_i;
                wp_reg <= ~wp_reg;
            end
            if (pop)
                rp_reg <= ~rp_reg;
            if (push && !pop)
                cnt_reg <= cnt_reg + 2'h1;
            else if (pop && !push)
                cnt_reg <= cnt_reg - 2'h1;
        end
    end
endmodule // bcu_buf2
`default_nettype wire

// ### bcu_exec.v
// Execution unit for the ascending repeating block copy and the
// user data space byte move. Assumes a decoder hands over the opcode
// bytes and register values with start_i, and a memory port whose
// ack_i comes one or more cycles after req_o and carries MMU status.
//
// Contract
// - Opcode ED B0 starts the ascending repeating block copy.
// - Each copy step reads at source pointer, writes at target pointer.
// - Per byte: pointers plus one, count minus one, repeat until zero.
// - A starting count of zero moves 65,536 bytes.
// - Interrupt accepted between bytes; first-byte PC saved for resume.
// - User load translates source with the user-mode data mapping.
// - User store translates target with user data mapping; source kept.
// - User move: carry 0 on success, 1 on failure.
// - Successful user move leaves all flags but carry.
// - Failed user move: write protect into Z, valid bit into V.
// - Opcode ED 86 loads accumulator from user data space via pointer.
// - Opcode ED 8E stores accumulator to user data space via pointer.
// - Indexed form: prefix bit picks first/second index, plus displacement.
//
// Our own choices: the placing of the registers and strobed register access.
`timescale 1ns/10ps
`default_nettype none
`include "bcu_defines.vh"
module bcu_exec #(
    parameter AW = 16
) (
    input wire core_clk_i,
    input wire rst_i,
    input wire start_i,
    input wire idx_i,
    input wire [7:0] pfx_i,
    input wire [7:0] op0_i,
    input wire [7:0] op1_i,
    input wire [7:0] disp_i,
    input wire sys_mode_i,
    input wire [AW-1:0] pc_i,
    input wire [AW-1:0] src_ptr_i,
    input wire [AW-1:0] tgt_ptr_i,
    input wire [15:0] cnt_i,
    input wire [AW-1:0] idx_first_i,
    input wire [AW-1:0] idx_second_i,
    input wire [7:0] acc_i,
    input wire [7:0] flags_i,
    input wire irq_pend_i,
    output reg mem_req_o,
    output reg mem_we_o,
    output reg mem_user_o,
    output reg mem_nolog_o,
    output reg [AW-1:0] mem_addr_o,
    output reg [7:0] mem_wdata_o,
    input wire mem_ack_i,
    input wire [7:0] mem_rdata_i,
    input wire mem_fault_i,
    input wire mem_wp_i,
    input wire mem_valid_i,
    input wire [3:0] bus_addr_i,
    input wire [31:0] bus_wdata_i,
    input wire bus_we_i,
    input wire bus_re_i,
    output reg [31:0] bus_rdata_o,
    output reg busy_o,
    output reg done_o,
    output reg bad_op_o,
    output reg priv_trap_o,
    output reg irq_take_o,
    output reg [AW-1:0] resume_pc_o,
    output reg [AW-1:0] src_ptr_o,
    output reg [AW-1:0] tgt_ptr_o,
    output reg [15:0] cnt_o,
    output reg [7:0] acc_o,
    output reg [7:0] flags_o
);
    localparam S_IDLE = 3'h0;
    localparam S_RD = 3'h1;
    localparam S_RDW = 3'h2;
    localparam S_WR = 3'h3;
    localparam S_WRW = 3'h4;
    localparam S_UMV = 3'h5;
    localparam S_UMW = 3'h6;

    reg [2:0] st_reg;
    reg uld_reg;
    reg irq_en_reg;
    reg last_fault_reg;
    reg [15:0] moved_reg;
    reg [AW-1:0] uaddr_reg;

    // Buffer between the read and write halves of a copy step
    wire buf_in_ready;
    wire buf_out_valid;
    wire [7:0] buf_out_data;
    wire buf_push = (st_reg == S_RDW) && mem_ack_i;
    wire buf_pop = (st_reg == S_WRW) && mem_ack_i;

    bcu_buf2 #(
        .W(8)
    ) u_buf (
        .core_clk_i(core_clk_i),
        .rst_i(rst_i),
        .in_valid_i(buf_push),
        .in_ready_o(buf_in_ready),
        .in_data_i(mem_rdata_i),
        .out_valid_o(buf_out_valid),
        .out_ready_i(buf_pop),
        .out_data_o(buf_out_data)
    );

    wire is_ed = (op0_i == `BCU_PFX_ED);
    wire has_pfx = ((pfx_i & `BCU_PFX_MASK) == `BCU_PFX_IDX);
    wire dec_copy = is_ed && !has_pfx && (op1_i == `BCU_OP_COPY);
    wire dec_uld = is_ed && (op1_i == `BCU_OP_ULD);
    wire dec_ust = is_ed && (op1_i == `BCU_OP_UST);
    wire [AW-1:0] idx_base = pfx_i[`BCU_PFX_SEL] ? idx_second_i : idx_first_i;
    wire [AW-1:0] disp_ext = {{(AW-8){disp_i[7]}}, disp_i};
    wire [AW-1:0] uaddr = (idx_i && has_pfx) ? idx_base + disp_ext : src_ptr_i;
    wire [15:0] cnt_dec = cnt_o - 16'h0001;

    always @(posedge core_clk_i) begin
        if (rst_i) begin
            st_reg <= S_IDLE;
            uld_reg <= 1'b0;
            uaddr_reg <= {AW{1'b0}};
            mem_req_o <= 1'b0;
            mem_we_o <= 1'b0;
            mem_user_o <= 1'b0;
            mem_nolog_o <= 1'b0;
            mem_addr_o <= {AW{1'b0}};
            mem_wdata_o <= 8'h00;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            bad_op_o <= 1'b0;
            priv_trap_o <= 1'b0;
            irq_take_o <= 1'b0;
            resume_pc_o <= {AW{1'b0}};
            src_ptr_o <= {AW{1'b0}};
            tgt_ptr_o <= {AW{1'b0}};
            cnt_o <= 16'h0000;
            acc_o <= 8'h00;
            flags_o <= 8'h00;
            last_fault_reg <= 1'b0;
            moved_reg <= 16'h0000;
        end else begin
            done_o <= 1'b0;
            bad_op_o <= 1'b0;
            priv_trap_o <= 1'b0;
            irq_take_o <= 1'b0;
            case (st_reg)
                S_IDLE: begin
                    if (start_i) begin
                        src_ptr_o <= src_ptr_i;
                        tgt_ptr_o <= tgt_ptr_i;
                        cnt_o <= cnt_i;
                        acc_o <= acc_i;
                        flags_o <= flags_i;
                        resume_pc_o <= pc_i;
                        uaddr_reg <= uaddr;
                        uld_reg <= dec_uld;
                        moved_reg <= 16'h0000;
                        if (dec_copy) begin
                            busy_o <= 1'b1;
                            st_reg <= S_RD;
                        end else if (dec_uld || dec_ust) begin
                            if (!sys_mode_i) begin
                                priv_trap_o <= 1'b1;
                                done_o <= 1'b1;
                            end else begin
                                busy_o <= 1'b1;
                                st_reg <= S_UMV;
                            end
                        end else begin
                            bad_op_o <= 1'b1;
                            done_o <= 1'b1;
                        end
                    end
                end
                S_RD: begin
                    // Stall the read while the buffer has no room
                    if (buf_in_ready) begin
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b0;
                        mem_user_o <= 1'b0;
                        mem_nolog_o <= 1'b0;
                        mem_addr_o <= src_ptr_o;
                        st_reg <= S_RDW;
                    end
                end
                S_RDW: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        st_reg <= S_WR;
                    end
                end
                S_WR: begin
                    if (buf_out_valid) begin
                        mem_req_o <= 1'b1;
                        mem_we_o <= 1'b1;
                        mem_addr_o <= tgt_ptr_o;
                        mem_wdata_o <= buf_out_data;
                        st_reg <= S_WRW;
                    end
                end
                S_WRW: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o <= 1'b0;
                        src_ptr_o <= src_ptr_o + {{(AW-1){1'b0}}, 1'b1};
                        tgt_ptr_o <= tgt_ptr_o + {{(AW-1){1'b0}}, 1'b1};
                        cnt_o <= cnt_dec;
                        moved_reg <= moved_reg + 16'h0001;
                        // Decrement before the zero test makes zero mean full range
                        if (cnt_dec == 16'h0000) begin
                            flags_o[`BCU_F_H] <= 1'b0;
                            flags_o[`BCU_F_V] <= 1'b0;
                            flags_o[`BCU_F_N] <= 1'b0;
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                            st_reg <= S_IDLE;
                        end else if (irq_pend_i && irq_en_reg) begin
                            // Registers stay updated; re-execution resumes the copy
                            irq_take_o <= 1'b1;
                            busy_o <= 1'b0;
                            done_o <= 1'b1;
                            st_reg <= S_IDLE;
                        end else begin
                            st_reg <= S_RD;
                        end
                    end
                end
                S_UMV: begin
                    mem_req_o <= 1'b1;
                    mem_we_o <= ~uld_reg;
                    mem_user_o <= 1'b1;
                    mem_nolog_o <= 1'b1;
                    mem_addr_o <= uaddr_reg;
                    mem_wdata_o <= acc_o;
                    st_reg <= S_UMW;
                end
                S_UMW: begin
                    if (mem_ack_i) begin
                        mem_req_o <= 1'b0;
                        mem_we_o <= 1'b0;
                        mem_user_o <= 1'b0;
                        mem_nolog_o <= 1'b0;
                        last_fault_reg <= mem_fault_i;
                        // Only carry moves on success; Z and V follow only on failure
                        flags_o[`BCU_F_C] <= mem_fault_i;
                        if (mem_fault_i) begin
                            flags_o[`BCU_F_Z] <= mem_wp_i;
                            flags_o[`BCU_F_V] <= mem_valid_i;
                        end else if (uld_reg) begin
                            acc_o <= mem_rdata_i;
                        end
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        st_reg <= S_IDLE;
                    end
                end
                default: begin
                    st_reg <= S_IDLE;
                end
            endcase
        end
    end

    // Register port: control, status, bytes moved
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            irq_en_reg <= `BCU_CTRL_RST;
            bus_rdata_o <= 32'h00000000;
        end else begin
            if (bus_we_i && (bus_addr_i == `BCU_ADR_CTRL))
                irq_en_reg <= bus_wdata_i[0];
            bus_rdata_o <= 32'h00000000;
            if (bus_re_i) begin
                case (bus_addr_i)
                    `BCU_ADR_CTRL: bus_rdata_o <= {31'h00000000, irq_en_reg};
                    `BCU_ADR_STAT: bus_rdata_o <= {27'h0000000, last_fault_reg, busy_o, st_reg};
                    `BCU_ADR_CNT: bus_rdata_o <= {16'h0000, moved_reg};
                    default: bus_rdata_o <= 32'h00000000;
                endcase
            end
        end
    end
endmodule // bcu_exec
`default_nettype wire

// ### bcu_exec_chk.sv
// Checker for bcu_exec: memory handshake, mapping choice and flag results.
// Bound into bcu_exec; sees only its ports.
`timescale 1ns/10ps
`default_nettype none
`include "bcu_defines.vh"
module bcu_exec_chk (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic start_i,
    input wire logic busy_o,
    input wire logic [7:0] op0_i,
    input wire logic [7:0] op1_i,
    input wire logic sys_mode_i,
    input wire logic mem_req_o,
    input wire logic mem_we_o,
    input wire logic mem_user_o,
    input wire logic mem_nolog_o,
    input wire logic mem_ack_i,
    input wire logic mem_fault_i,
    input wire logic mem_wp_i,
    input wire logic mem_valid_i,
    input wire logic done_o,
    input wire logic priv_trap_o,
    input wire logic irq_take_o,
    input wire logic [15:0] cnt_o,
    input wire logic [7:0] flags_o
);
    logic copy_reg, user_reg, flt_reg, wp_reg, vb_reg;
    wire take = start_i && !busy_o && op0_i == `BCU_PFX_ED;
    wire umove = op1_i == `BCU_OP_ULD || op1_i == `BCU_OP_UST;
    // Status of the last access is kept so the flags can be judged at done
    always @(posedge core_clk_i) begin
        if (rst_i) begin
            copy_reg <= 1'b0;
            user_reg <= 1'b0;
        end else if (take) begin
            copy_reg <= op1_i == `BCU_OP_COPY;
            user_reg <= umove && sys_mode_i;
        end
        if (mem_req_o && mem_ack_i) begin
            flt_reg <= mem_fault_i;
            wp_reg <= mem_wp_i;
            vb_reg <= mem_valid_i;
        end
    end
    default clocking @(posedge core_clk_i); endclocking
    default disable iff (rst_i);
    a_req_holds: assert property (mem_req_o && !mem_ack_i |=> mem_req_o && $stable(mem_we_o))
        else $error("memory request changed before ack");
    a_req_ends: assert property (mem_req_o && mem_ack_i |=> !mem_req_o)
        else $error("memory request held past ack");
    a_user_map: assert property (mem_req_o && user_reg |-> mem_user_o && mem_nolog_o)
        else $error("user move access without user mapping or no-log");
    a_copy_mode: assert property (mem_req_o && copy_reg |-> !mem_user_o)
        else $error("copy access used user mapping");
    a_copy_flags: assert property (done_o && copy_reg && !irq_take_o |-> cnt_o == 16'h0000 &&
        !flags_o[`BCU_F_H] && !flags_o[`BCU_F_V] && !flags_o[`BCU_F_N]) else $error("copy end state wrong");
    a_fault_flags: assert property (done_o && user_reg && flt_reg |-> flags_o[`BCU_F_C] &&
        flags_o[`BCU_F_Z] == wp_reg && flags_o[`BCU_F_V] == vb_reg) else $error("failed move flags wrong");
    a_ok_carry: assert property (done_o && user_reg && !flt_reg |-> !flags_o[`BCU_F_C])
        else $error("carry set on good move");
    a_trap_quiet: assert property (take && umove && !sys_mode_i |->
        (!mem_req_o throughout (##[1:2] (done_o && priv_trap_o)))) else $error("user move not trapped");
    c_copy: cover property (done_o && copy_reg && !irq_take_o);
    c_irq: cover property (done_o && irq_take_o);
    c_fault: cover property (done_o && user_reg && flt_reg);
endmodule // bcu_exec_chk
bind bcu_exec bcu_exec_chk u_chk (.core_clk_i(core_clk_i), .rst_i(rst_i), .start_i(start_i), .busy_o(busy_o),
    .op0_i(op0_i), .op1_i(op1_i), .sys_mode_i(sys_mode_i), .mem_req_o(mem_req_o), .mem_we_o(mem_we_o),
    .mem_user_o(mem_user_o), .mem_nolog_o(mem_nolog_o), .mem_ack_i(mem_ack_i), .mem_fault_i(mem_fault_i),
    .mem_wp_i(mem_wp_i), .mem_valid_i(mem_valid_i), .done_o(done_o), .priv_trap_o(priv_trap_o),
    .irq_take_o(irq_take_o), .cnt_o(cnt_o), .flags_o(flags_o));
`default_nettype wire

// ### bcu_mem_model.sv
// Memory behind the MMU for the bcu_exec bench.
// Pages from F000 fail translation; protect and valid come from address bits.
`timescale 1ns/10ps
`default_nettype none
module bcu_mem_model (
    input wire logic core_clk_i,
    input wire logic rst_i,
    input wire logic slow_i,
    input wire logic req_i,
    input wire logic we_i,
    input wire logic [15:0] addr_i,
    input wire logic [7:0] wdata_i,
    output logic ack_o,
    output logic [7:0] rdata_o,
    output logic fault_o,
    output logic wp_o,
    output logic valid_o
);
    logic [7:0] mem [0:65535];
    logic [1:0] wait_reg;
    initial for (int i = 0; i < 65536; i++) mem[i] = 8'(i) ^ 8'(i >> 8);
    always @(posedge core_clk_i) begin
        ack_o <= 1'b0;
        // Read data toggles outside ack so stale bytes never pass
        rdata_o <= ~rdata_o;
        if (rst_i) begin
            wait_reg <= 2'h0;
            rdata_o <= 8'h00;
        end else if (req_i && !ack_o) begin
            wait_reg <= wait_reg + 2'h1;
            if (wait_reg == {slow_i, 1'b0}) begin
                wait_reg <= 2'h0;
                ack_o <= 1'b1;
                rdata_o <= mem[addr_i];
                fault_o <= &addr_i[15:12];
                wp_o <= addr_i[0];
                valid_o <= !addr_i[1];
                if (we_i && !(&addr_i[15:12]))
                    mem[addr_i] <= wdata_i;
            end
        end
    end
endmodule // bcu_mem_model
`default_nettype wire

// ### bcu_exec_tb.sv
// Self-checking bench for bcu_exec with the memory model on its far side.
// Drives instructions and register-bus cycles; one clock, synchronous reset.
`timescale 1ns/10ps
`default_nettype none
`include "bcu_defines.vh"
module bcu_exec_tb;
    logic clk = 1'b0, rst = 1'b1, start = 1'b0, idx = 1'b0, sys = 1'b1, irq = 1'b0, slow = 1'b0, bwe = 1'b0;
    logic bre = 1'b0;
    logic [7:0] pfx = 8'h00, op1 = 8'h00, disp = 8'h00, acc = 8'h00, flg = 8'h00;
    logic [15:0] pc = 16'h0100, src = 16'h0000, tgt = 16'h0000, cnt = 16'h0000, ix1 = 16'h0000, ix2 = 16'h0000;
    logic [3:0] badr = 4'h0;
    logic [31:0] bwd = 32'h0000_0000;
    wire req, we, usr, nolog, ack, flt, wp, vb, busy, done, bad, trap, itk;
    wire [15:0] maddr, rpc, src_o, tgt_o, cnt_o;
    wire [7:0] wd, rd, acc_o, flg_o;
    wire [31:0] brd;
    int failures = 0, num_checks = 0, cycles = 0, n;
    always #5 clk = ~clk;
    bcu_exec dut (.core_clk_i(clk), .rst_i(rst), .start_i(start), .idx_i(idx), .pfx_i(pfx), .op0_i(`BCU_PFX_ED),
        .op1_i(op1), .disp_i(disp), .sys_mode_i(sys), .pc_i(pc), .src_ptr_i(src), .tgt_ptr_i(tgt), .cnt_i(cnt),
        .idx_first_i(ix1), .idx_second_i(ix2), .acc_i(acc), .flags_i(flg), .irq_pend_i(irq), .mem_req_o(req),
        .mem_we_o(we), .mem_user_o(usr), .mem_nolog_o(nolog), .mem_addr_o(maddr), .mem_wdata_o(wd),
        .mem_ack_i(ack), .mem_rdata_i(rd), .mem_fault_i(flt), .mem_wp_i(wp), .mem_valid_i(vb),
        .bus_addr_i(badr), .bus_wdata_i(bwd), .bus_we_i(bwe), .bus_re_i(bre), .bus_rdata_o(brd), .busy_o(busy),
        .done_o(done), .bad_op_o(bad), .priv_trap_o(trap), .irq_take_o(itk), .resume_pc_o(rpc),
        .src_ptr_o(src_o), .tgt_ptr_o(tgt_o), .cnt_o(cnt_o), .acc_o(acc_o), .flags_o(flg_o));
    bcu_mem_model u_mem (.core_clk_i(clk), .rst_i(rst), .slow_i(slow), .req_i(req), .we_i(we), .addr_i(maddr),
        .wdata_i(wd), .ack_o(ack), .rdata_o(rd), .fault_o(flt), .wp_o(wp), .valid_o(vb));
    function automatic logic [7:0] pat(input logic [15:0] a);
        return a[7:0] ^ a[15:8];
    endfunction
    task automatic check(input string what, input logic [31:0] exp, input logic [31:0] seen);
        num_checks++;
        if (seen !== exp) begin
            failures++;
            $display("wrong value %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", num_checks, failures);
        if (failures == 0 && num_checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic bus(input logic w, input logic [3:0] a, input logic [31:0] d);
        @(posedge clk);
        badr <= a;
        bwd <= d;
        bwe <= w;
        bre <= !w;
        @(posedge clk);
        bwe <= 1'b0;
        bre <= 1'b0;
        @(negedge clk);
        if (!w) check("bus_rdata", d, brd);
    endtask
    // Returns at the falling edge inside the done cycle, so pulses are still up
    task automatic run(input logic [7:0] op, input logic [15:0] s, input logic [15:0] c);
        @(posedge clk);
        op1 <= op;
        src <= s;
        cnt <= c;
        start <= 1'b1;
        @(posedge clk);
        start <= 1'b0;
        n = 0;
        @(negedge clk);
        while (done !== 1'b1 && n++ < 800) @(negedge clk);
        check("done", 1, done);
    endtask
    always @(posedge clk) begin
        cycles++;
        if (cycles == 20000) begin
            failures++;
            tally_and_finish;
        end
    end
    initial begin
        repeat (5) @(posedge clk);
        rst <= 1'b0;
        bus(1'b0, `BCU_ADR_CTRL, 32'h0000_0001);
        bus(1'b0, 4'hC, 32'h0000_0000);
        flg <= 8'hFF;
        tgt <= 16'h2210;
        run(`BCU_OP_COPY, 16'h1125, 16'h0003);
        check("src", 16'h1128, src_o);
        check("tgt", 16'h2213, tgt_o);
        check("cnt", 16'h0000, cnt_o);
        check("flags", 8'hE9, flg_o);
        for (int i = 0; i < 3; i++) check("copied", pat(16'h1125 + i), u_mem.mem[16'h2210 + i]);
        $display("test copy finished");
        irq <= 1'b1;
        pc <= 16'h0200;
        run(`BCU_OP_COPY, 16'h3000, 16'h0000);
        check("irq_take", 1, itk);
        check("resume_pc", 16'h0200, rpc);
        check("cnt", 16'hFFFF, cnt_o);
        check("src", 16'h3001, src_o);
        bus(1'b0, `BCU_ADR_CNT, 32'h0000_0001);
        bus(1'b1, `BCU_ADR_CTRL, 32'h0000_0000);
        run(`BCU_OP_COPY, 16'h3000, 16'h0002);
        check("irq_take", 0, itk);
        check("cnt", 16'h0000, cnt_o);
        bus(1'b1, `BCU_ADR_CTRL, 32'h0000_0001);
        irq <= 1'b0;
        $display("test interrupt finished");
        slow <= 1'b1;
        run(`BCU_OP_ULD, 16'h8D07, 16'h0000);
        check("acc", pat(16'h8D07), acc_o);
        check("flags", 8'hFE, flg_o);
        acc <= 8'h77;
        run(`BCU_OP_UST, 16'h8D08, 16'h0000);
        check("stored", 8'h77, u_mem.mem[16'h8D08]);
        check("acc", 8'h77, acc_o);
        flg <= 8'h00;
        run(`BCU_OP_UST, 16'hF123, 16'h0000);
        check("flags", 8'h41, flg_o);
        check("kept", pat(16'hF123), u_mem.mem[16'hF123]);
        bus(1'b0, `BCU_ADR_STAT, 32'h0000_0010);
        sys <= 1'b0;
        flg <= 8'h5A;
        run(`BCU_OP_ULD, 16'h8D07, 16'h0000);
        check("trap", 1, trap);
        check("flags", 8'h5A, flg_o);
        sys <= 1'b1;
        $display("test user move finished");
        idx <= 1'b1;
        pfx <= 8'hDD;
        ix1 <= 16'h3000;
        disp <= 8'hFE;
        run(`BCU_OP_ULD, 16'h0000, 16'h0000);
        check("acc", pat(16'h2FFE), acc_o);
        pfx <= 8'hFD;
        ix2 <= 16'h4000;
        disp <= 8'h02;
        run(`BCU_OP_ULD, 16'h0000, 16'h0000);
        check("acc", pat(16'h4002), acc_o);
        idx <= 1'b0;
        run(8'h00, 16'h0000, 16'h0000);
        check("bad_op", 1, bad);
        $display("test decode finished");
        tally_and_finish;
    end
endmodule // bcu_exec_tb
`default_nettype wire
